// ===== verilog/trace_mux_pkg.sv
// Purpose: Shared constants for the debug signal bank multiplexer
// Assumes: One design clock; the control link pins are asynchronous to it
// Notes: Control word is shifted least significant bit first
package trace_mux_pkg;
	localparam int MIN_PINS = 4;
	localparam int MAX_PINS = 128;
	localparam int MAX_BANKS = 32;
	localparam int SEL_W = 5;
	localparam int CMD_W = 8;
	localparam int CMD_SEL_LSB = 0;
	localparam int STAT_SYNC_BIT = 5;
	localparam int STAT_TDM_BIT = 6;
	localparam logic [SEL_W-1:0] SEL_RESET = 5'h00;
	localparam logic [CMD_W-1:0] CMD_RESET = 8'h00;
	localparam int SYNC_DEPTH = 2;

	// Sampling phase of the output clock; Gray order
	typedef enum logic {
		PH_FIRST = 1'b0,
		PH_SECOND = 1'b1
	} phase_e;

	function automatic logic bank_count_ok(input int n);
		bank_count_ok = (n == 1) || (n == 2) || (n == 4) || (n == 8) || (n == 16) || (n == 32);
	endfunction : bank_count_ok
endpackage : trace_mux_pkg

// ===== verilog/debug_signal_bank_mux.sv
// Purpose: Route one of several equal-width signal banks to the debug pins
// Assumes: Probes are on clock_i; link pins are sampled through two flip-flops
// Notes: Timing variant data path is combinational by design
// Behaviour
// - All banks equal width, 4..128 pins
// - Bank count is 1,2,4,8,16 or 32
// - Each pin carries its bit of selected bank
// - Compression sends two bank signals per pin
// - Compression only in the state variant
// - State variant drives an extra sampling clock
// - State variant registers probes before multiplexing
// - Timing variant passes probes combinationally
// - Bank switch leaves surrounding design untouched
// - Analyzer can read which variant this is
// - Control flip-flops run on clock_i, stepped by sampled test clock rises
// - Timing variant has no probe-path flip-flop
`timescale 1ns/1ps
`default_nettype none
module debug_signal_bank_mux
	import trace_mux_pkg::*;
#(
	parameter int PIN_COUNT = 8,
	parameter int BANK_COUNT = 4,
	parameter bit SYNC_CORE = 1'b1,
	parameter bit TDM_ON = 1'b0
) (
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic [BANK_COUNT*PIN_COUNT*((SYNC_CORE && TDM_ON) ? 2 : 1)-1:0] probe_i,
	input wire logic tck_i,
	input wire logic tdi_i,
	input wire logic user_sel_i,
	input wire logic capture_i,
	input wire logic shift_i,
	input wire logic update_i,
	output logic tdo_o,
	output wire logic [PIN_COUNT-1:0] dbg_data_o,
	output logic dbg_clk_o
);
	// Compression is refused outside the state variant
	localparam bit TDM = SYNC_CORE && TDM_ON;
	localparam int BANK_W = PIN_COUNT * (TDM ? 2 : 1);
	localparam int PROBE_W = BANK_COUNT * BANK_W;

	function automatic logic [PIN_COUNT-1:0] bank_slice(
		input logic [PROBE_W-1:0] bus,
		input logic [SEL_W-1:0] sel,
		input logic half
	);
		bank_slice = bus[int'(sel) * BANK_W + int'(half) * PIN_COUNT +: PIN_COUNT];
	endfunction : bank_slice

	////////////////////////////////////////////////////////////////////////////
	// Link pin synchronisers and test clock edge
	logic [4:0] link_s1_r;
	logic [4:0] link_s2_r;
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			link_s1_r <= 5'h00;
			link_s2_r <= 5'h00;
		end else begin
			link_s1_r <= {update_i, shift_i, capture_i, user_sel_i, tdi_i};
			link_s2_r <= link_s1_r;
		end
	end

	logic tck_s_r;
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			tck_s_r <= 1'b0;
		end else begin
			tck_s_r <= tck_i;
		end
	end

	logic tck_s2_r;
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			tck_s2_r <= 1'b0;
		end else begin
			tck_s2_r <= tck_s_r;
		end
	end

	logic tck_prev_r;
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			tck_prev_r <= 1'b0;
		end else begin
			tck_prev_r <= tck_s2_r;
		end
	end

	wire tck_rise = tck_s2_r && !tck_prev_r;
	wire tdi_s = link_s2_r[0];
	wire usel_s = link_s2_r[1];
	wire capture_s = link_s2_r[2];
	wire shift_s = link_s2_r[3];
	wire update_s = link_s2_r[4];

	////////////////////////////////////////////////////////////////////////////
	// Control shift register and bank select
	logic [CMD_W-1:0] cmd_r;
	logic [SEL_W-1:0] sel_r;
	wire [SEL_W-1:0] cmd_sel = cmd_r[CMD_SEL_LSB +: SEL_W];
	wire do_capture = tck_rise && usel_s && capture_s;
	wire do_shift = tck_rise && usel_s && shift_s && !capture_s;
	// Out-of-range bank numbers are dropped, so the pins never float to junk
	wire do_update = tck_rise && usel_s && update_s && (int'(cmd_sel) < BANK_COUNT);
	wire [CMD_W-1:0] status_word = (CMD_W'(sel_r) << CMD_SEL_LSB)
		| (CMD_W'(SYNC_CORE) << STAT_SYNC_BIT) | (CMD_W'(TDM) << STAT_TDM_BIT);

	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			cmd_r <= CMD_RESET;
			tdo_o <= 1'b0;
		end else if (do_capture) begin
			cmd_r <= status_word;
			tdo_o <= status_word[0];
		end else if (do_shift) begin
			cmd_r <= {tdi_s, cmd_r[CMD_W-1:1]};
			tdo_o <= cmd_r[1];
		end
	end

	// Select changes in one cycle only; design clocks and nets are untouched
	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			sel_r <= SEL_RESET;
		end else if (do_update) begin
			sel_r <= cmd_sel;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Data path
	generate
		if (SYNC_CORE) begin : g_state
			logic [PROBE_W-1:0] probe_r;
			logic [PIN_COUNT-1:0] dout_r;
			phase_e phase_r;
			wire load_now = TDM || (phase_r == PH_FIRST);
			wire [PIN_COUNT-1:0] pick = bank_slice(probe_r, sel_r, TDM && (phase_r == PH_SECOND));
			always_ff @(posedge clock_i) begin
				if (!rstn_i) begin
					probe_r <= '0;
					dout_r <= '0;
					phase_r <= PH_FIRST;
					dbg_clk_o <= 1'b0;
				end else begin
					probe_r <= probe_i;
					phase_r <= (phase_r == PH_FIRST) ? PH_SECOND : PH_FIRST;
					dbg_clk_o <= (phase_r == PH_FIRST);
					if (load_now) begin
						dout_r <= pick;
					end
				end
			end
			assign dbg_data_o = dout_r;
		end else begin : g_timing
			// No flip-flop between probe and pad; only sel_r is registered
			assign dbg_data_o = bank_slice(probe_i, sel_r, 1'b0);
			always_ff @(posedge clock_i) begin
				dbg_clk_o <= 1'b0;
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Checks
	property p_build_ok;
		@(posedge clock_i)
		PIN_COUNT >= MIN_PINS && PIN_COUNT <= MAX_PINS && bank_count_ok(BANK_COUNT)
		&& BANK_COUNT <= MAX_BANKS;
	endproperty
	a_build_ok: assert property (p_build_ok) else $error("bad sizing");

	sequence s_update;
		do_update;
	endsequence

	property p_sel_update;
		@(posedge clock_i) disable iff (!rstn_i)
		s_update |=> (sel_r == $past(cmd_sel));
	endproperty
	a_sel_update: assert property (p_sel_update) else $error("select not loaded");

	property p_sel_hold;
		@(posedge clock_i) disable iff (!rstn_i)
		!do_update |=> $stable(sel_r);
	endproperty
	a_sel_hold: assert property (p_sel_hold) else $error("select moved");

	property p_status;
		@(posedge clock_i) disable iff (!rstn_i)
		do_capture |=> (cmd_r[STAT_SYNC_BIT] == SYNC_CORE) && (cmd_r[STAT_TDM_BIT] == TDM)
			&& (cmd_r[CMD_SEL_LSB +: SEL_W] == $past(sel_r));
	endproperty
	a_status: assert property (p_status) else $error("variant status wrong");

	generate
		if (SYNC_CORE) begin : g_chk_state
			property p_probe_reg;
				@(posedge clock_i) disable iff (!rstn_i)
				// First cycle out of reset holds no registered sample yet
				$past(rstn_i) |-> g_state.probe_r == $past(probe_i);
			endproperty
			a_probe_reg: assert property (p_probe_reg) else $error("probe not registered");

			property p_clk_toggle;
				@(posedge clock_i) disable iff (!rstn_i)
				$rose(dbg_clk_o) |=> $fell(dbg_clk_o) ##1 $rose(dbg_clk_o);
			endproperty
			a_clk_toggle: assert property (p_clk_toggle) else $error("sample clock stalled");

			property p_first_half;
				@(posedge clock_i) disable iff (!rstn_i)
				(g_state.phase_r == PH_FIRST)
				|=> dbg_data_o == bank_slice($past(g_state.probe_r), $past(sel_r), 1'b0);
			endproperty
			a_first_half: assert property (p_first_half) else $error("wrong bank bits");

			property p_second_half;
				@(posedge clock_i) disable iff (!rstn_i)
				(g_state.phase_r == PH_SECOND) |=> (TDM ?
				dbg_data_o == bank_slice($past(g_state.probe_r), $past(sel_r), 1'b1)
				: $stable(dbg_data_o));
			endproperty
			a_second_half: assert property (p_second_half) else $error("pair phase wrong");
		end else begin : g_chk_timing
			property p_comb_path;
				@(posedge clock_i) disable iff (!rstn_i)
				dbg_data_o == bank_slice(probe_i, sel_r, 1'b0) && !dbg_clk_o;
			endproperty
			a_comb_path: assert property (p_comb_path) else $error("timing path not direct");
		end
	endgenerate
endmodule : debug_signal_bank_mux
`default_nettype wire

// ===== sim/analyzer_model.sv
// Purpose: Analyzer side of the control link: sends frames, reads status
// Assumes: Link pins change only just after clock_i rising edges
// Notes: Test clock stands low between frames
`timescale 1ns/1ps
`default_nettype none
module analyzer_model (
	input wire logic clock_i,
	input wire logic [1:0] tdo_i,
	output logic tck_o,
	output logic tdi_o,
	output logic user_sel_o,
	output logic capture_o,
	output logic shift_o,
	output logic update_o
);
	initial begin
		tck_o = 1'b0;
		tdi_o = 1'b0;
		user_sel_o = 1'b0;
		capture_o = 1'b0;
		shift_o = 1'b0;
		update_o = 1'b0;
	end
	////////////////////////////////////////////////////////////////
	// Four clocks high, four low: 160 ns, slow enough for the sampler
	task automatic pulse();
		@(posedge clock_i);
		tck_o <= 1'b1;
		repeat (4) @(posedge clock_i);
		tck_o <= 1'b0;
		repeat (3) @(posedge clock_i);
	endtask : pulse
	// Capture, eight shifts LSB first, update; rd holds both cores' status
	task automatic access(input logic [7:0] wr, input logic us, output logic [15:0] rd);
		@(posedge clock_i);
		user_sel_o <= us;
		capture_o <= 1'b1;
		pulse();
		{rd[8], rd[0]} = tdo_i;
		capture_o <= 1'b0;
		shift_o <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			tdi_o <= wr[i];
			pulse();
			if (i < 7) begin
				{rd[i+9], rd[i+1]} = tdo_i;
			end
		end
		shift_o <= 1'b0;
		update_o <= 1'b1;
		pulse();
		update_o <= 1'b0;
		user_sel_o <= 1'b0;
		tdi_o <= ~wr[7];
	endtask : access
endmodule : analyzer_model
`default_nettype wire

// ===== sim/debug_signal_bank_mux_tb.sv
// Purpose: Self-checking bench for the state and timing bank multiplexers
// Assumes: Both cores share one analyzer link
// Notes: State core built with compression; timing core asks for it too
`timescale 1ns/1ps
`default_nettype none
module debug_signal_bank_mux_tb;
	logic clock_i, rstn_i, tck, tdi, usel, cap, shf, upd, clk_a, clk_b;
	logic [1:0] tdo;
	logic [63:0] pa;
	logic [31:0] pb;
	logic [7:0] dat_a, dat_b;
	int err_total, checks;
	debug_signal_bank_mux #(.TDM_ON(1'b1)) dut_u (
		.clock_i(clock_i), .rstn_i(rstn_i), .probe_i(pa), .tck_i(tck), .tdi_i(tdi),
		.user_sel_i(usel), .capture_i(cap), .shift_i(shf), .update_i(upd),
		.tdo_o(tdo[0]), .dbg_data_o(dat_a), .dbg_clk_o(clk_a));
	debug_signal_bank_mux #(.SYNC_CORE(1'b0), .TDM_ON(1'b1)) dut_t_u (
		.clock_i(clock_i), .rstn_i(rstn_i), .probe_i(pb), .tck_i(tck), .tdi_i(tdi),
		.user_sel_i(usel), .capture_i(cap), .shift_i(shf), .update_i(upd),
		.tdo_o(tdo[1]), .dbg_data_o(dat_b), .dbg_clk_o(clk_b));
	analyzer_model ana_u (.clock_i(clock_i), .tdo_i(tdo), .tck_o(tck), .tdi_o(tdi),
		.user_sel_o(usel), .capture_o(cap), .shift_o(shf), .update_o(upd));
	always #10 clock_i = ~clock_i;
	////////////////////////////////////////////////////////////////
	task automatic expect_eq(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : expect_eq
	task automatic give_verdict();
		$display("checks=%0d err_total=%0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : give_verdict
	////////////////////////////////////////////////////////////////
	// Status after reset: select 0, variant and compression flags
	task automatic t_status();
		logic [15:0] rd;
		ana_u.access(8'h00, 1'b1, rd);
		expect_eq(rd, 16'h0060);
	endtask : t_status
	// Pin contents for select s: pair halves on clock phases, timing path zero delay
	task automatic check_pins(input int s);
		@(posedge clock_i);
		#1;
		if (clk_a !== 1'b1) begin
			@(posedge clock_i);
			#1;
		end
		expect_eq({8'h00, dat_a}, {8'h00, pa[s*16 +: 8]});
		@(posedge clock_i);
		pb <= ~pb;
		#1;
		expect_eq({7'h00, clk_a, dat_a}, {8'h00, pa[s*16+8 +: 8]});
		expect_eq({7'h00, clk_b, dat_b}, {8'h00, pb[s*8 +: 8]});
	endtask : check_pins
	// Walk banks 1 to 3, then an out-of-range select that must be ignored, then back to bank 0
	task automatic t_banks();
		logic [4:0] w [5] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h00};
		logic [4:0] cur;
		logic [15:0] rd;
		cur = 5'h00;
		for (int i = 0; i < 5; i++) begin
			ana_u.access({3'b000, w[i]}, 1'b1, rd);
			expect_eq(rd, {3'b000, cur, 3'b011, cur});
			if (w[i] < 5'h04) begin
				cur = w[i];
			end
			check_pins(int'(cur));
		end
	endtask : t_banks
	// A frame with our register not selected must leave the select alone
	task automatic t_unselected();
		logic [15:0] rd;
		ana_u.access(8'h02, 1'b0, rd);
		ana_u.access(8'h00, 1'b1, rd);
		expect_eq(rd, 16'h0060);
		check_pins(0);
	endtask : t_unselected
	// Reset in mid-run drops the select back to bank 0
	task automatic t_reset();
		logic [15:0] rd;
		ana_u.access(8'h03, 1'b1, rd);
		expect_eq(rd, 16'h0060);
		check_pins(3);
		@(posedge clock_i);
		rstn_i <= 1'b0;
		repeat (10) @(posedge clock_i);
		#1;
		expect_eq({5'h00, tdo, clk_a, dat_a}, 16'h0000);
		@(posedge clock_i);
		rstn_i <= 1'b1;
		repeat (2) @(posedge clock_i);
		check_pins(0);
		ana_u.access(8'h00, 1'b1, rd);
		expect_eq(rd, 16'h0060);
	endtask : t_reset
	////////////////////////////////////////////////////////////////
	initial begin
		clock_i = 1'b0;
		rstn_i = 1'b0;
		err_total = 0;
		checks = 0;
		pa = 64'hfedc_ba98_7654_3210;
		pb = 32'hc3a5_5a3c;
		repeat (10) @(posedge clock_i);
		rstn_i <= 1'b1;
		repeat (2) @(posedge clock_i);
		t_status();
		t_banks();
		t_unselected();
		t_reset();
		give_verdict();
	end
	initial begin
		#200000;
		err_total++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		give_verdict();
	end
endmodule : debug_signal_bank_mux_tb
`default_nettype wire
